// File: hdl/tasd_pkg.sv
// Shared constants, types and helpers for the tiled address swizzle stage
package tasd_pkg;
    // Address and configuration widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int CFG_AW = 20;
    localparam int FENCE_COUNT = 16;
    localparam int PITCH_W = 10;
    // Device register offsets
    localparam logic [19:0] REG_RENDER_MODE = 20'h04030;
    localparam logic [19:0] REG_DISPLAY_CTL = 20'h45000;
    localparam logic [19:0] REG_TILE_CTL = 20'h04100;
    localparam logic [19:0] REG_FENCE0 = 20'h08000;
    localparam logic [19:0] FENCE_SPAN = 20'h00080;
    // Fence word layout: low word start page, valid, walk; high word last page, pitch-1
    localparam int FENCE_WORD_BIT = 2;
    localparam int FENCE_IDX_LSB = 3;
    localparam int FENCE_VALID_BIT = 0;
    localparam int FENCE_WALK_BIT = 1;
    localparam int PAGE_LSB = 12;
    // Swizzle field positions in each copy
    localparam int RENDER_SWZ_LSB = 4;
    localparam int DISPLAY_SWZ_LSB = 13;
    localparam int TILE_SWZ_LSB = 0;
    localparam logic [1:0] SWZ_NONE = 2'h0;
    localparam logic [1:0] SWZ_BIT6 = 2'h1;
    // Channel select bit and swizzle source bits
    localparam int CHAN_BIT = 6;
    localparam int SWZ_SRC_A = 9;
    localparam int SWZ_SRC_B = 10;
    // Tile geometry
    localparam int TILE_X_WIDTH = 512;
    localparam int TILE_X_ROWS = 8;
    localparam int TILE_Y_WIDTH = 128;
    localparam int TILE_Y_ROWS = 32;
    localparam logic [9:0] XPITCH_MAX_M1 = 10'h0ff;
    // Controller Avalon byte offsets
    localparam logic [4:0] AV_CTRL = 5'h00;
    localparam logic [4:0] AV_STATUS = 5'h04;
    localparam logic [4:0] AV_FENCE_LO = 5'h08;
    localparam logic [4:0] AV_FENCE_HI = 5'h0c;
    localparam logic [4:0] AV_FENCE_CMD = 5'h10;
    localparam logic [4:0] AV_RD_ADDR = 5'h14;
    localparam logic [4:0] AV_RD_DATA = 5'h18;
    localparam int CTRL_DRAM_EN_BIT = 4;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_ERR_BIT = 2;

    // Access streams
    typedef enum logic [2:0] {STR_HOST, STR_RENDER, STR_SAMPLER, STR_BLIT, STR_DISPLAY, STR_OVERLAY} tasd_stream_t;

    // Only the 01 encoding swizzles; reserved codes behave as none
    function automatic logic swz_enabled(input logic [1:0] field);
        return field == SWZ_BIT6;
    endfunction

    // True when a valid fence covers the page of addr
    function automatic logic fence_covers(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] addr);
        return lo[FENCE_VALID_BIT] && addr[31:PAGE_LSB] >= lo[31:PAGE_LSB] && addr[31:PAGE_LSB] <= hi[31:PAGE_LSB];
    endfunction
endpackage

// File: hdl/tasd_cfg_if.sv
// Configuration link between the controller and the swizzle stage
`timescale 1ns/10ps
interface tasd_cfg_if;
    logic cfg_we;
    logic cfg_re;
    logic [19:0] cfg_addr;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic cfg_rvalid;
    modport dev (input cfg_we, input cfg_re, input cfg_addr, input cfg_wdata, output cfg_rdata, output cfg_rvalid);
    modport ctl (output cfg_we, output cfg_re, output cfg_addr, output cfg_wdata, input cfg_rdata, input cfg_rvalid);
endinterface

// File: hdl/tasd_swizzle_dev.sv
// Tiling detect and channel swizzle stage ahead of the DRAM arbiter
// Operation
// - Address bit 6 selects the DRAM channel
// - Linear accesses keep bit 6 unchanged
// - Y-major swizzle: bit6 = bit6 xor bit9
// - X-major swizzle: bit6 xor bit9 xor bit10
// - Swizzle field 00 none, 01 swizzle, reset 00
// - Software sets swizzle before enabling DRAM
// - Three copies programmed alike, one per stream group
// - Field at render 5:4, display 14:13
// - Host uses fences; internal streams use surface parameters
// - Host access inside valid fence is tiled
// - Internal clients ignore fence enables
// - Fences never tile private graphics space
// - Sixteen independent fence window descriptors
// - Fence works only while valid, page granular
// - Pitch 1..256 X tiles, 1..1024 Y tiles; only fenced host X pitch is clamped, internal streams pass X pitch up to 1024
// - Software never programs overlapping valid fences
// - Each fence carries an X/Y walk selector
// - Surface tiled flag and walk select tiling
// - Tiled surface pitch is whole tile widths
// - X tile 512B by 8, Y 128B by 32
// - Fenced host address minus fence base first
`timescale 1ns/10ps
module tasd_swizzle_dev
#(
    parameter int NUM_FENCES = tasd_pkg::FENCE_COUNT
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Configuration link
    tasd_cfg_if.dev cfg,
    // Incoming access
    input wire logic i_req_valid,
    input wire tasd_pkg::tasd_stream_t i_req_stream,
    input wire logic [tasd_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic i_req_tiled,
    input wire logic i_req_walk_y,
    input wire logic [tasd_pkg::PITCH_W-1:0] i_req_pitch_m1,
    input wire logic i_req_private,
    // Access toward the arbiter
    output logic o_out_valid,
    output logic [tasd_pkg::ADDR_W-1:0] o_out_addr,
    output logic o_out_chan,
    output logic o_out_tiled,
    output logic o_out_walk_y,
    output logic [tasd_pkg::PITCH_W-1:0] o_out_pitch_m1,
    output logic o_out_fence_hit,
    output logic [$clog2(NUM_FENCES)-1:0] o_out_fence_idx
);
    import tasd_pkg::*;

    localparam int FIDX_W = $clog2(NUM_FENCES);

    logic [31:0] render_mode_q;
    logic [31:0] display_ctl_q;
    logic [31:0] tile_ctl_q;
    logic [31:0] fence_lo_q [NUM_FENCES];
    logic [31:0] fence_hi_q [NUM_FENCES];
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic cfg_in_fence;
    logic [19:0] cfg_rel;
    logic [FIDX_W-1:0] cfg_fidx;
    logic hit;
    logic [FIDX_W-1:0] hit_idx;
    logic tiled_d;
    logic walk_y_d;
    logic fenced_d;
    logic [1:0] swz_field;
    logic [ADDR_W-1:0] addr_d;
    logic [PITCH_W-1:0] pitch_d;
    logic out_valid_q;
    logic [ADDR_W-1:0] out_addr_q;
    logic out_tiled_q;
    logic out_walk_y_q;
    logic [PITCH_W-1:0] out_pitch_q;
    logic out_fence_q;
    logic [FIDX_W-1:0] out_fidx_q;

    // Configuration address decode for the fence table
    assign cfg_rel = cfg.cfg_addr - REG_FENCE0;
    assign cfg_in_fence = cfg.cfg_addr >= REG_FENCE0 && cfg_rel < FENCE_SPAN;
    assign cfg_fidx = cfg_rel[FENCE_IDX_LSB +: FIDX_W];

    // Swizzle control copies, one for host, one for display/overlay, one for the other streams, reset to no swizzle
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            render_mode_q <= 32'h0;
            display_ctl_q <= 32'h0;
            tile_ctl_q <= 32'h0;
        end
        else if (cfg.cfg_we)
        begin
            if (cfg.cfg_addr == REG_RENDER_MODE)
                render_mode_q <= cfg.cfg_wdata;
            if (cfg.cfg_addr == REG_DISPLAY_CTL)
                display_ctl_q <= cfg.cfg_wdata;
            if (cfg.cfg_addr == REG_TILE_CTL)
                tile_ctl_q <= cfg.cfg_wdata;
        end
    end

    // Sixteen fence descriptors, cleared to invalid at reset
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            for (int i = 0; i < NUM_FENCES; i++)
            begin
                fence_lo_q[i] <= 32'h0;
                fence_hi_q[i] <= 32'h0;
            end
        end
        else if (cfg.cfg_we && cfg_in_fence)
        begin
            if (cfg_rel[FENCE_WORD_BIT])
                fence_hi_q[cfg_fidx] <= cfg.cfg_wdata;
            else
                fence_lo_q[cfg_fidx] <= cfg.cfg_wdata;
        end
    end

    // Register read-back, answered one cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rdata_q <= 32'h0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= cfg.cfg_re;
            if (cfg.cfg_re)
            begin
                if (cfg.cfg_addr == REG_RENDER_MODE)
                    rdata_q <= render_mode_q;
                else if (cfg.cfg_addr == REG_DISPLAY_CTL)
                    rdata_q <= display_ctl_q;
                else if (cfg.cfg_addr == REG_TILE_CTL)
                    rdata_q <= tile_ctl_q;
                else if (cfg_in_fence)
                    rdata_q <= cfg_rel[FENCE_WORD_BIT] ? fence_hi_q[cfg_fidx] : fence_lo_q[cfg_fidx];
                else
                    rdata_q <= 32'h0;
            end
        end
    end

    assign cfg.cfg_rdata = rdata_q;
    assign cfg.cfg_rvalid = rvalid_q;

    // Fence lookup; overlap is left undefined, highest index wins here
    always_comb
    begin
        hit = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < NUM_FENCES; i++)
        begin
            if (fence_covers(fence_lo_q[i], fence_hi_q[i], i_req_addr))
            begin
                hit = 1'b1;
                hit_idx = i[FIDX_W-1:0];
            end
        end
    end

    // Tiling detect per stream and the swizzle copy that stream uses
    always_comb
    begin
        fenced_d = 1'b0;
        addr_d = i_req_addr;
        if (i_req_stream == STR_HOST)
        begin
            fenced_d = hit && !i_req_private;
            tiled_d = fenced_d;
            walk_y_d = fenced_d && fence_lo_q[hit_idx][FENCE_WALK_BIT];
            pitch_d = fence_hi_q[hit_idx][PITCH_W-1:0];
            if (fenced_d && !walk_y_d && pitch_d > XPITCH_MAX_M1)
                pitch_d = XPITCH_MAX_M1;
            if (fenced_d)
                addr_d = i_req_addr - {fence_lo_q[hit_idx][31:PAGE_LSB], {PAGE_LSB{1'b0}}};
        end
        else
        begin
            tiled_d = i_req_tiled;
            walk_y_d = i_req_tiled && i_req_walk_y;
            pitch_d = i_req_pitch_m1;
        end
        case (i_req_stream)
            STR_HOST: swz_field = tile_ctl_q[TILE_SWZ_LSB +: 2];
            STR_DISPLAY, STR_OVERLAY: swz_field = display_ctl_q[DISPLAY_SWZ_LSB +: 2];
            default: swz_field = render_mode_q[RENDER_SWZ_LSB +: 2];
        endcase
        // Linear accesses and reserved codes leave bit 6 alone
        if (tiled_d && swz_enabled(swz_field))
        begin
            if (walk_y_d)
                addr_d[CHAN_BIT] = addr_d[CHAN_BIT] ^ addr_d[SWZ_SRC_A];
            else
                addr_d[CHAN_BIT] = addr_d[CHAN_BIT] ^ addr_d[SWZ_SRC_A] ^ addr_d[SWZ_SRC_B];
        end
    end

    // One-cycle output register toward the arbiter
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            out_valid_q <= 1'b0;
            out_addr_q <= '0;
            out_tiled_q <= 1'b0;
            out_walk_y_q <= 1'b0;
            out_pitch_q <= '0;
            out_fence_q <= 1'b0;
            out_fidx_q <= '0;
        end
        else
        begin
            out_valid_q <= i_req_valid;
            if (i_req_valid)
            begin
                out_addr_q <= addr_d;
                out_tiled_q <= tiled_d;
                out_walk_y_q <= walk_y_d;
                out_pitch_q <= pitch_d;
                out_fence_q <= fenced_d;
                out_fidx_q <= hit_idx;
            end
        end
    end

    assign o_out_valid = out_valid_q;
    assign o_out_addr = out_addr_q;
    assign o_out_chan = out_addr_q[CHAN_BIT];
    assign o_out_tiled = out_tiled_q;
    assign o_out_walk_y = out_walk_y_q;
    assign o_out_pitch_m1 = out_pitch_q;
    assign o_out_fence_hit = out_fence_q;
    assign o_out_fence_idx = out_fidx_q;
endmodule

// File: hdl/tasd_swizzle_ctl.sv
// Controller that programs the swizzle stage from Avalon-MM registers
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps
module tasd_swizzle_ctl
#(
    parameter int NUM_FENCES = tasd_pkg::FENCE_COUNT
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Avalon-MM slave
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // DRAM access enable toward the memory system
    output logic o_dram_en,
    // Configuration link
    tasd_cfg_if.ctl cfg
);
    import tasd_pkg::*;

    typedef enum {ST_IDLE, ST_WR_RENDER, ST_WR_DISPLAY, ST_WR_TILE, ST_FENCE_LO, ST_FENCE_HI, ST_READ} tasd_state_t;

    tasd_state_t state_q;
    logic wait_q;
    logic [31:0] readdata_q;
    logic [1:0] swz_q;
    logic dram_en_q;
    logic done_q;
    logic err_q;
    logic [31:0] stage_lo_q;
    logic [31:0] stage_hi_q;
    logic [3:0] fidx_q;
    logic [31:0] sh_lo_q [NUM_FENCES];
    logic [31:0] sh_hi_q [NUM_FENCES];
    logic [31:0] rd_data_q;
    logic [19:0] rd_addr_q;
    logic we_q;
    logic re_q;
    logic [19:0] addr_q;
    logic [31:0] wdata_q;
    logic acc;
    logic wr_done;
    logic overlap;
    logic fence_ok;
    logic [31:0] status;

    assign acc = (i_avs_read || i_avs_write) && state_q == ST_IDLE;
    assign wr_done = i_avs_write && !wait_q;
    assign status = {29'h0, err_q, done_q, state_q != ST_IDLE};

    // Overlap check of the staged fence against the other valid fences
    always_comb
    begin
        overlap = 1'b0;
        for (int i = 0; i < NUM_FENCES; i++)
        begin
            if (i[3:0] != i_avs_writedata[3:0] && sh_lo_q[i][FENCE_VALID_BIT]
                && stage_lo_q[31:PAGE_LSB] <= sh_hi_q[i][31:PAGE_LSB]
                && sh_lo_q[i][31:PAGE_LSB] <= stage_hi_q[31:PAGE_LSB])
                overlap = 1'b1;
        end
        fence_ok = !stage_lo_q[FENCE_VALID_BIT]
            || (!overlap && stage_hi_q[31:PAGE_LSB] >= stage_lo_q[31:PAGE_LSB]);
    end

    // Avalon handshake: one wait cycle once the sequencer is idle, then the access completes
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wait_q <= 1'b1;
            readdata_q <= 32'h0;
        end
        else if (acc && wait_q)
        begin
            wait_q <= 1'b0;
            case (i_avs_address)
                AV_CTRL: readdata_q <= {27'h0, dram_en_q, 2'h0, swz_q};
                AV_STATUS: readdata_q <= status;
                AV_FENCE_LO: readdata_q <= stage_lo_q;
                AV_FENCE_HI: readdata_q <= stage_hi_q;
                AV_RD_ADDR: readdata_q <= {12'h0, rd_addr_q};
                AV_RD_DATA: readdata_q <= rd_data_q;
                default: readdata_q <= 32'h0;
            endcase
        end
        else
            wait_q <= 1'b1;
    end

    // Software-visible control and staging registers
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            swz_q <= SWZ_NONE;
            dram_en_q <= 1'b0;
            stage_lo_q <= 32'h0;
            stage_hi_q <= 32'h0;
            fidx_q <= 4'h0;
            rd_addr_q <= 20'h0;
        end
        else if (wr_done)
        begin
            case (i_avs_address)
                AV_CTRL:
                begin
                    if (!dram_en_q)
                        swz_q <= i_avs_writedata[1:0];
                    dram_en_q <= i_avs_writedata[CTRL_DRAM_EN_BIT] && (dram_en_q || done_q);
                end
                AV_FENCE_LO: stage_lo_q <= i_avs_writedata;
                AV_FENCE_HI: stage_hi_q <= i_avs_writedata;
                AV_FENCE_CMD: fidx_q <= i_avs_writedata[3:0];
                AV_RD_ADDR: rd_addr_q <= i_avs_writedata[19:0];
                default: ;
            endcase
        end
    end

    // Sequencer: broadcast swizzle to all copies, commit fences, read back
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= ST_IDLE;
            we_q <= 1'b0;
            re_q <= 1'b0;
            addr_q <= 20'h0;
            wdata_q <= 32'h0;
            rd_data_q <= 32'h0;
        end
        else
        begin
            we_q <= 1'b0;
            re_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (wr_done && i_avs_address == AV_CTRL && !dram_en_q)
                        state_q <= ST_WR_RENDER;
                    else if (wr_done && i_avs_address == AV_FENCE_CMD && fence_ok)
                        state_q <= ST_FENCE_LO;
                    else if (wr_done && i_avs_address == AV_RD_ADDR)
                    begin
                        state_q <= ST_READ;
                        re_q <= 1'b1;
                        addr_q <= i_avs_writedata[19:0];
                    end
                end
                ST_WR_RENDER:
                begin
                    we_q <= 1'b1;
                    addr_q <= REG_RENDER_MODE;
                    wdata_q <= {26'h0, swz_q, 4'h0};
                    state_q <= ST_WR_DISPLAY;
                end
                ST_WR_DISPLAY:
                begin
                    we_q <= 1'b1;
                    addr_q <= REG_DISPLAY_CTL;
                    wdata_q <= {17'h0, swz_q, 13'h0};
                    state_q <= ST_WR_TILE;
                end
                ST_WR_TILE:
                begin
                    we_q <= 1'b1;
                    addr_q <= REG_TILE_CTL;
                    wdata_q <= {30'h0, swz_q};
                    state_q <= ST_IDLE;
                end
                ST_FENCE_LO:
                begin
                    we_q <= 1'b1;
                    addr_q <= REG_FENCE0 + {13'h0, fidx_q, 3'h0};
                    wdata_q <= stage_lo_q;
                    state_q <= ST_FENCE_HI;
                end
                ST_FENCE_HI:
                begin
                    we_q <= 1'b1;
                    addr_q <= REG_FENCE0 + {13'h0, fidx_q, 3'h4};
                    wdata_q <= stage_hi_q;
                    state_q <= ST_IDLE;
                end
                ST_READ:
                begin
                    if (cfg.cfg_rvalid)
                    begin
                        rd_data_q <= cfg.cfg_rdata;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Shadow fence table, completion and error flags; error set wins over clear
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            for (int i = 0; i < NUM_FENCES; i++)
            begin
                sh_lo_q[i] <= 32'h0;
                sh_hi_q[i] <= 32'h0;
            end
            done_q <= 1'b0;
            err_q <= 1'b0;
        end
        else
        begin
            if (state_q == ST_FENCE_HI)
            begin
                sh_lo_q[fidx_q] <= stage_lo_q;
                sh_hi_q[fidx_q] <= stage_hi_q;
            end
            if (state_q == ST_WR_TILE)
                done_q <= 1'b1;
            else if (state_q == ST_WR_RENDER)
                done_q <= 1'b0;
            if (wr_done && i_avs_address == AV_FENCE_CMD && !fence_ok && state_q == ST_IDLE)
                err_q <= 1'b1;
            else if (wr_done && i_avs_address == AV_STATUS && i_avs_writedata[ST_ERR_BIT])
                err_q <= 1'b0;
        end
    end

    assign o_avs_readdata = readdata_q;
    assign o_avs_waitrequest = wait_q;
    assign o_dram_en = dram_en_q;
    assign cfg.cfg_we = we_q;
    assign cfg.cfg_re = re_q;
    assign cfg.cfg_addr = addr_q;
    assign cfg.cfg_wdata = wdata_q;
endmodule

// File: dv/tasd_link_monitor.sv
// Assertions on the configuration link between controller and stage
`timescale 1ns/10ps
module tasd_link_monitor
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Link signals
    input wire logic cfg_we,
    input wire logic cfg_re,
    input wire logic [19:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    import tasd_pkg::*;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);
    // Reads are answered exactly one cycle later, and only then
    rd_answer_a: assert property (cfg_re |=> cfg_rvalid)
        else $error("read strobe not answered");
    rd_cause_a: assert property (cfg_rvalid |-> $past(cfg_re))
        else $error("read answer without strobe");
    rd_hold_a: assert property (!cfg_re |=> $stable(cfg_rdata))
        else $error("read data moved without strobe");
    // Field placement in the render and display swizzle copies
    render_field_a: assert property (cfg_we && cfg_addr == REG_RENDER_MODE |-> cfg_wdata[31:6] == 26'h0)
        else $error("render copy outside its field");
    disp_field_a: assert property (cfg_we && cfg_addr == REG_DISPLAY_CTL |-> cfg_wdata[12:0] == 13'h0)
        else $error("display copy outside its field");
    // All three copies carry the same code, back to back
    disp_copy_a: assert property (cfg_we && cfg_addr == REG_RENDER_MODE |=>
        cfg_we && cfg_addr == REG_DISPLAY_CTL && cfg_wdata[14:13] == $past(cfg_wdata[5:4]))
        else $error("display copy differs");
    tile_copy_a: assert property (cfg_we && cfg_addr == REG_DISPLAY_CTL |=>
        cfg_we && cfg_addr == REG_TILE_CTL && cfg_wdata[1:0] == $past(cfg_wdata[14:13]))
        else $error("tile copy differs");
    fence_range_a: assert property (cfg_we && cfg_addr[19:12] == 8'h08 |-> cfg_addr[11:7] == 5'h0)
        else $error("fence write past sixteen windows");
    // Main traffic seen
    cover property (cfg_re ##1 cfg_rvalid);
    cover property (cfg_we && cfg_addr == REG_TILE_CTL && cfg_wdata[1:0] == SWZ_BIT6);
    cover property (cfg_we && cfg_addr == 20'h08078);
endmodule

// File: dv/testbench.sv
// Self-checking bench for the swizzle controller and stage
`timescale 1ns/10ps
module testbench;
    import tasd_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic [4:0] av_a = 5'h0;
    logic av_r = 1'b0;
    logic av_w = 1'b0;
    logic [31:0] av_d = 32'h0;
    logic [31:0] av_q;
    logic av_wait, dram_en, o_v, o_ch, o_t, o_y, o_h;
    logic rq_v = 1'b0;
    tasd_stream_t rq_s = STR_HOST;
    logic [31:0] rq_a = 32'h0;
    logic rq_t = 1'b0;
    logic rq_y = 1'b0;
    logic [9:0] rq_p = 10'h0;
    logic rq_pv = 1'b0;
    logic [31:0] o_a, r, x, a, b;
    logic [9:0] o_p;
    logic [3:0] o_i, f;
    logic [1:0] swz;
    logic y;
    tasd_stream_t st;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    integer seed = 32'hd289;
    tasd_cfg_if link ();
    tasd_swizzle_ctl tasd_swizzle_ctl_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_avs_address(av_a),
        .i_avs_read(av_r), .i_avs_write(av_w), .i_avs_writedata(av_d), .o_avs_readdata(av_q),
        .o_avs_waitrequest(av_wait), .o_dram_en(dram_en), .cfg(link.ctl));
    tasd_swizzle_dev tasd_swizzle_dev_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .cfg(link.dev),
        .i_req_valid(rq_v), .i_req_stream(rq_s), .i_req_addr(rq_a), .i_req_tiled(rq_t), .i_req_walk_y(rq_y),
        .i_req_pitch_m1(rq_p), .i_req_private(rq_pv), .o_out_valid(o_v), .o_out_addr(o_a), .o_out_chan(o_ch),
        .o_out_tiled(o_t), .o_out_walk_y(o_y), .o_out_pitch_m1(o_p), .o_out_fence_hit(o_h), .o_out_fence_idx(o_i));
    tasd_link_monitor tasd_link_monitor_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .cfg_we(link.cfg_we),
        .cfg_re(link.cfg_re), .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata), .cfg_rdata(link.cfg_rdata),
        .cfg_rvalid(link.cfg_rvalid));
    // Clock
    always #4 i_clk_sys = ~i_clk_sys;
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge i_clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            give_verdict();
        end
    end
    // Avalon access held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [4:0] ad, input logic [31:0] d);
        av_a <= ad;
        av_d <= d;
        av_w <= wr;
        av_r <= !wr;
        @(posedge i_clk_sys);
        while (av_wait !== 1'b0)
            @(posedge i_clk_sys);
        r = av_q;
        av_w <= 1'b0;
        av_r <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic wait_done();
        r = 32'h0;
        while (r[ST_DONE_BIT] !== 1'b1)
            av(1'b0, AV_STATUS, 32'h0);
    endtask
    // Base of window i; windows never overlap
    function automatic logic [31:0] fb(input logic [3:0] i);
        return 32'h0010_0000 + {12'h0, i, 16'h0};
    endfunction
    // Expected channel bit after swizzle
    function automatic logic [31:0] swz6(input logic [31:0] v, input logic t, input logic wy);
        if (t && swz == 2'h1)
            v[6] = v[6] ^ v[9] ^ (!wy && v[10]);
        return v;
    endfunction
    // One access through the stage, checked at the next cycle
    task automatic acc(input tasd_stream_t s, input logic [31:0] ad, input logic t, input logic wy, input logic pv,
        input logic [31:0] ea, input logic et, input logic eh, input logic ey, input logic [3:0] ei);
        rq_s <= s;
        rq_a <= ad;
        rq_t <= t;
        rq_y <= wy;
        rq_pv <= pv;
        rq_p <= x[17:8];
        rq_v <= 1'b1;
        @(posedge i_clk_sys);
        rq_v <= 1'b0;
        @(negedge i_clk_sys);
        check(32'(o_v), 32'h1);
        check(o_a, ea);
        check(32'(o_ch), 32'(ea[6]));
        check(32'({o_t, o_h}), 32'({et, eh}));
        if (et)
            check(32'(o_y), 32'(ey));
        if (eh)
            check(32'({o_i, o_p}), {18'h0, ei, (ei[3:1] == 3'h6 ? (ei[0] ? 10'h3ff : 10'h0ff) : 10'h3f)});
        @(posedge i_clk_sys);
    endtask
    initial
    begin
        repeat (20) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        @(posedge i_clk_sys);
        av(1'b0, AV_CTRL, 32'h0);
        check(r, 32'h0);
        // Sixteen windows, walk alternating, 11 invalid, 12 and 13 wide; then an overlapping commit that must drop
        for (int i = 0; i < 16; i++)
        begin
            av(1'b1, AV_FENCE_LO, fb(4'(i)) | 32'(i % 2) << 1 | 32'(i != 11));
            av(1'b1, AV_FENCE_HI, fb(4'(i)) + 32'h3000 | (i / 2 == 6 ? 32'h3ff : 32'h3f));
            av(1'b1, AV_FENCE_CMD, 32'(i));
        end
        av(1'b1, AV_FENCE_LO, fb(4'h0) | 32'h1);
        av(1'b1, AV_FENCE_CMD, 32'hf);
        av(1'b0, AV_STATUS, 32'h0);
        check(32'(r[ST_ERR_BIT]), 32'h1);
        av(1'b1, AV_STATUS, 32'h4);
        av(1'b0, AV_STATUS, 32'h0);
        check(32'(r[ST_ERR_BIT]), 32'h0);
        a = fb(4'hb) + 32'h240;
        acc(STR_HOST, a, 1'b0, 1'b0, 1'b0, a, 1'b0, 1'b0, 1'b0, 4'hb);
        $display("fence setup test done");
        for (int s = 0; s < 4; s++)
        begin
            swz = 2'(s);
            av(1'b1, AV_CTRL, 32'(swz));
            wait_done();
            av(1'b1, AV_RD_ADDR, 32'(REG_RENDER_MODE));
            av(1'b0, AV_RD_DATA, 32'h0);
            check(r, 32'(swz) << 4);
            av(1'b1, AV_RD_ADDR, 32'(REG_DISPLAY_CTL));
            av(1'b0, AV_RD_DATA, 32'h0);
            check(r, 32'(swz) << 13);
            repeat (40)
            begin
                x = $random(seed);
                f = x[31:28];
                b = fb(f);
                a = b + 32'(x[13:0]);
                st = tasd_stream_t'(3'(1 + x[4:2] % 5));
                y = x[1] && st != STR_DISPLAY && st != STR_OVERLAY;
                case (x[27:26])
                    2'h0: acc(STR_HOST, a, x[0], x[1], 1'b0, f == 4'hb ? a : swz6(a - b, 1'b1, f[0]),
                        f != 4'hb, f != 4'hb, f[0], f);
                    2'h1: acc(STR_HOST, a | 32'h0100_0000, x[0], x[1], 1'b0, a | 32'h0100_0000, 1'b0, 1'b0, 1'b0, f);
                    2'h2: acc(STR_HOST, a, x[0], x[1], 1'b1, a, 1'b0, 1'b0, 1'b0, f);
                    default: acc(st, a, x[0], y, 1'b0, swz6(a, x[0], y), x[0], 1'b0, y, f);
                endcase
            end
            $display("swizzle code %0d test done", s);
        end
        // Swizzle locked while DRAM access is enabled
        av(1'b1, AV_CTRL, 32'h1);
        wait_done();
        av(1'b1, AV_CTRL, 32'h11);
        av(1'b1, AV_CTRL, 32'h12);
        av(1'b0, AV_CTRL, 32'h0);
        check(r, 32'h11);
        check(32'(dram_en), 32'h1);
        $display("lock test done");
        give_verdict();
    end
endmodule
